// ---- cfsp_ctrl_port.sv ----
// Host-side control FIFO and SBP-2 agent control register slice
// What this block does
// - last update byte commits packet for sending
// - lowest byte address holds most significant byte
// - quadlets staged through byte stacking buffer
// - receive register read pops one FIFO quadlet
// - registers clear to zero at reset
// - management reset bit pulses, self-clears
// - command agent reset pulses, self-clears
// - transfer reset clears engine and block size
// - status-send bit releases loaded status
// - abort bit abandons current command
// - read-only unsolicited status allowed flag
// - gap register reserved, reads zero
`timescale 1ns/1ps
module cfsp_ctrl_port
   import cfsp_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // 8-bit host register port, same clock domain
   input wire logic [7:0] host_addr_in,
   input wire logic host_wr_in,
   input wire logic host_rd_in,
   input wire logic [7:0] host_wdata_in,
   output logic [7:0] host_rdata_out,
   output logic host_wr_ready_out,
   // Control transmit FIFO quadlet stream, bit 32 marks packet end
   output logic tx_valid_out,
   output logic [32:0] tx_data_out,
   input wire logic tx_ready_in,
   // Control receive FIFO pop port
   input wire logic rx_valid_in,
   input wire logic [31:0] rx_fifo_quadlet_field_in,
   output logic rx_pop_out,
   // SBP-2 engine controls, one-cycle pulses
   output logic mgmt_agent_reset_out,
   output logic cmd_agent_reset_out,
   output logic xfer_engine_reset_out,
   output logic xfer_block_size_clear_out,
   output logic cmd_set_status_send_out,
   output logic current_cmd_abort_out,
   // Status from the SBP-2 engines
   input wire logic unsolicited_allowed_flag_in
);
   // =====================================
   // Address decode
   logic [5:0] quad_idx;
   logic [1:0] lane;
   logic hit_first;
   logic hit_last;
   logic hit_rx;
   logic hit_agent;
   logic wr_go;
   logic tx_push;
   logic tx_in_ready;
   logic [31:0] tx_quad;
   logic [31:0] rx_quad;
   logic rx_load;
   logic [7:0] rdata_next;
   logic [7:0] rdata_reg;
   logic [7:0] stage_wdata;

   assign quad_idx = host_addr_in[7:2];
   assign lane = host_addr_in[1:0];
   assign hit_first = (quad_idx == CFSP_FIRST_MORE_BASE[7:2]);
   assign hit_last = (quad_idx == CFSP_TX_LAST_BASE[7:2]);
   assign hit_rx = (quad_idx == CFSP_RX_QUAD_BASE[7:2]);
   assign hit_agent = (quad_idx == CFSP_AGENT_CTRL_BASE[7:2]);

   // Writes to the transmit path are dropped while the buffer is full; the host must hold them until host_wr_ready_out
   assign host_wr_ready_out = tx_in_ready;
   assign wr_go = host_wr_in && tx_in_ready;

   // =====================================
   // Transmit staging: one stacking buffer shared by 50h and 54h
   logic tx_stage_wr;
   logic tx_is_last_reg;
   logic tx_push_reg;
   assign tx_stage_wr = wr_go && (hit_first || hit_last);
   assign stage_wdata = host_wdata_in;

   cfsp_stack_buf u_tx_stack (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .lane_in(lane),
      .wr_in(tx_stage_wr),
      .wdata_in(stage_wdata),
      .load_in(1'b0),
      .quad_in(CFSP_QUAD_RESET),
      .quad_out(tx_quad)
   );

   // Push happens one cycle after the byte at lane 3 lands in the stack
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         tx_push_reg <= 1'b0;
         tx_is_last_reg <= 1'b0;
      end else begin
         tx_push_reg <= tx_stage_wr && (lane == 2'h3);
         tx_is_last_reg <= hit_last;
      end
   end
   assign tx_push = tx_push_reg;

   // Ready is checked on the lane-3 write, a cycle before its push; another lane-3 write can push on the very next cycle
   cfsp_skid_buf u_tx_buf (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(tx_push),
      .in_data_in({tx_is_last_reg, tx_quad}),
      .in_ready_out(tx_in_ready),
      .out_valid_out(tx_valid_out),
      .out_data_out(tx_data_out),
      .out_ready_in(tx_ready_in)
   );

   // =====================================
   // Receive staging: first byte read loads a fresh quadlet
   assign rx_load = host_rd_in && hit_rx && (lane == 2'h0) && rx_valid_in;
   assign rx_pop_out = rx_load;

   cfsp_stack_buf u_rx_stack (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .lane_in(lane),
      .wr_in(1'b0),
      .wdata_in(CFSP_BYTE_RESET),
      .load_in(rx_load),
      .quad_in(rx_fifo_quadlet_field_in),
      .quad_out(rx_quad)
   );

   // =====================================
   // Agent control strobes, self-clearing after one cycle
   logic [31:0] agent_wr_bits;
   always_comb begin
      agent_wr_bits = CFSP_QUAD_RESET;
      case (lane)
         2'h0: agent_wr_bits[31:24] = host_wdata_in;
         2'h1: agent_wr_bits[23:16] = host_wdata_in;
         2'h2: agent_wr_bits[15:8] = host_wdata_in;
         default: agent_wr_bits[7:0] = host_wdata_in;
      endcase
   end

   logic agent_wr;
   assign agent_wr = host_wr_in && hit_agent;

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         mgmt_agent_reset_out <= 1'b0;
         cmd_agent_reset_out <= 1'b0;
         xfer_engine_reset_out <= 1'b0;
         xfer_block_size_clear_out <= 1'b0;
         cmd_set_status_send_out <= 1'b0;
         current_cmd_abort_out <= 1'b0;
      end else begin
         mgmt_agent_reset_out <= agent_wr && agent_wr_bits[31 - CFSP_MGMT_RST_POS];
         cmd_agent_reset_out <= agent_wr && agent_wr_bits[31 - CFSP_CMD_RST_POS];
         xfer_engine_reset_out <= agent_wr && agent_wr_bits[31 - CFSP_XFER_RST_POS];
         xfer_block_size_clear_out <= agent_wr && agent_wr_bits[31 - CFSP_XFER_RST_POS];
         cmd_set_status_send_out <= agent_wr && agent_wr_bits[31 - CFSP_STAT_SEND_POS];
         current_cmd_abort_out <= agent_wr && agent_wr_bits[31 - CFSP_ABORT_POS];
      end
   end

   // Flag read image: strobes already cleared, so only the flag shows
   logic [31:0] agent_rd;
   always_comb begin
      agent_rd = CFSP_QUAD_RESET;
      agent_rd[31 - CFSP_UNSOL_POS] = unsolicited_allowed_flag_in;
   end

   // =====================================
   // Read mux, registered one cycle after the strobe
   function automatic logic [7:0] cfsp_pick(input logic [31:0] q, input logic [1:0] l);
      logic [7:0] b;
      case (l)
         2'h0: b = q[31:24];
         2'h1: b = q[23:16];
         2'h2: b = q[15:8];
         default: b = q[7:0];
      endcase
      return b;
   endfunction

   // Receive lane 0 must see the quadlet being popped this cycle
   always_comb begin
      rdata_next = rdata_reg;
      if (host_rd_in) begin
         if (hit_first || hit_last) begin
            rdata_next = cfsp_pick(tx_quad, lane);
         end else if (hit_rx) begin
            rdata_next = rx_load ? cfsp_pick(rx_fifo_quadlet_field_in, lane)
                                 : cfsp_pick(rx_quad, lane);
         end else if (hit_agent) begin
            rdata_next = cfsp_pick(agent_rd, lane);
         end else begin
            rdata_next = CFSP_BYTE_RESET;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         rdata_reg <= CFSP_BYTE_RESET;
      end else begin
         rdata_reg <= rdata_next;
      end
   end
   assign host_rdata_out = rdata_reg;
endmodule

// ---- cfsp_pkg.sv ----
// Package: offsets, field positions, reset values for the control port slice
package cfsp_pkg;
   // Byte addresses on the 8-bit host port
   localparam logic [7:0] CFSP_FIRST_MORE_BASE = 8'h50;
   localparam logic [7:0] CFSP_TX_LAST_BASE = 8'h54;
   localparam logic [7:0] CFSP_RSVD_GAP_BASE = 8'h58;
   localparam logic [7:0] CFSP_RX_QUAD_BASE = 8'h5C;
   localparam logic [7:0] CFSP_AGENT_CTRL_BASE = 8'h60;
   // Agent control field positions, bit 00 being the quadlet MSB
   localparam int CFSP_MGMT_RST_POS = 1;
   localparam int CFSP_CMD_RST_POS = 3;
   localparam int CFSP_XFER_RST_POS = 5;
   localparam int CFSP_STAT_SEND_POS = 8;
   localparam int CFSP_ABORT_POS = 9;
   localparam int CFSP_UNSOL_POS = 10;
   // Reset values
   localparam logic [31:0] CFSP_QUAD_RESET = 32'h00000000;
   localparam logic [7:0] CFSP_BYTE_RESET = 8'h00;
   // Buffer depth
   localparam int CFSP_BUF_DEPTH = 2;
endpackage

// ---- cfsp_stack_buf.sv ----
// Byte stacking buffer: four bytes in or out of one quadlet
`timescale 1ns/1ps
module cfsp_stack_buf
   import cfsp_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // Byte side
   input wire logic [1:0] lane_in,
   input wire logic wr_in,
   input wire logic [7:0] wdata_in,
   // Quadlet load side
   input wire logic load_in,
   input wire logic [31:0] quad_in,
   // Assembled quadlet
   output logic [31:0] quad_out
);
   logic [31:0] quad_reg;

   // =====================================
   // Staging quadlet, lane 0 is bits 00:07 i.e. the MSB
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         quad_reg <= CFSP_QUAD_RESET;
      end else if (load_in) begin
         quad_reg <= quad_in;
      end else if (wr_in) begin
         case (lane_in)
            2'h0: quad_reg[31:24] <= wdata_in;
            2'h1: quad_reg[23:16] <= wdata_in;
            2'h2: quad_reg[15:8] <= wdata_in;
            default: quad_reg[7:0] <= wdata_in;
         endcase
      end
   end
   assign quad_out = quad_reg;
endmodule

// ---- cfsp_skid_buf.sv ----
// Two-entry valid/ready buffer for transmit quadlets
`timescale 1ns/1ps
module cfsp_skid_buf
   import cfsp_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // Fill side
   input wire logic in_valid_in,
   input wire logic [32:0] in_data_in,
   output logic in_ready_out,
   // Drain side
   output logic out_valid_out,
   output logic [32:0] out_data_out,
   input wire logic out_ready_in
);
   logic [32:0] mem_reg [CFSP_BUF_DEPTH];
   logic wptr_reg;
   logic rptr_reg;
   logic [1:0] cnt_reg;
   logic push;
   logic pop;

   // Honest full/empty from the fill count
   assign in_ready_out = (cnt_reg != 2'h2);
   assign out_valid_out = (cnt_reg != 2'h0);
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign out_data_out = mem_reg[rptr_reg];

   // Storage write
   always_ff @(posedge core_clk_in) begin
      if (push) begin
         mem_reg[wptr_reg] <= in_data_in;
      end
   end

   // Pointers and count
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         wptr_reg <= 1'b0;
         rptr_reg <= 1'b0;
         cnt_reg <= 2'h0;
      end else begin
         if (push) wptr_reg <= ~wptr_reg;
         if (pop) rptr_reg <= ~rptr_reg;
         cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// ---- cfsp_ctrl_port_checker.sv ----
// Checker: assertions on the control port slice pins
`timescale 1ns/1ps
module cfsp_ctrl_port_checker
   import cfsp_pkg::*;
(
   // Clock, reset, host port
   input wire logic core_clk_in, rst_n_in, host_wr_in, host_rd_in,
   input wire logic [7:0] host_addr_in, host_wdata_in, host_rdata_out,
   // Streams
   input wire logic tx_valid_out, tx_ready_in, rx_valid_in, rx_pop_out,
   input wire logic [32:0] tx_data_out,
   input wire logic [31:0] rx_fifo_quadlet_field_in,
   // Engine pulses and status
   input wire logic mgmt_agent_reset_out, cmd_agent_reset_out, xfer_engine_reset_out,
   input wire logic xfer_block_size_clear_out, cmd_set_status_send_out, current_cmd_abort_out,
   input wire logic unsolicited_allowed_flag_in
);
   // ==========
   // Decodes and assertions
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   wire logic w60 = host_wr_in && host_addr_in == CFSP_AGENT_CTRL_BASE;
   wire logic w61 = host_wr_in && host_addr_in == 8'h61;
   wire logic r5c = host_rd_in && host_addr_in == CFSP_RX_QUAD_BASE;
   a_mgmt_pulse: assert property (mgmt_agent_reset_out == $past(w60 && host_wdata_in[6]))
      else $error("mgmt reset pulse wrong");
   a_cmd_pulse: assert property (cmd_agent_reset_out == $past(w60 && host_wdata_in[4]))
      else $error("cmd reset pulse wrong");
   a_xfer_pulse: assert property (xfer_engine_reset_out == $past(w60 && host_wdata_in[2])
      && xfer_block_size_clear_out == xfer_engine_reset_out) else $error("xfer reset wrong");
   a_status_send: assert property (cmd_set_status_send_out == $past(w61 && host_wdata_in[7]))
      else $error("status send pulse wrong");
   a_abort_pulse: assert property (current_cmd_abort_out == $past(w61 && host_wdata_in[6]))
      else $error("abort pulse wrong");
   a_rx_pop_cause: assert property (rx_pop_out == (r5c && rx_valid_in))
      else $error("rx pop wrong");
   a_rx_msb_first: assert property (r5c && rx_valid_in |=>
      host_rdata_out == $past(rx_fifo_quadlet_field_in[31:24])) else $error("rx msb wrong");
   a_unsol_readback: assert property (host_rd_in && host_addr_in == 8'h61 |=>
      host_rdata_out == {2'b00, $past(unsolicited_allowed_flag_in), 5'h00}) else $error("61h bad");
   a_gap_zero: assert property (host_rd_in && host_addr_in[7:2] == 6'h16 |=>
      host_rdata_out == 8'h00) else $error("gap read not zero");
   a_tx_hold: assert property (tx_valid_out && !tx_ready_in |=>
      tx_valid_out && $stable(tx_data_out)) else $error("tx word dropped");
   c_mgmt: cover property (w60 && host_wdata_in[6]);
   c_stall: cover property (tx_valid_out && !tx_ready_in ##1 tx_valid_out);
   c_pop: cover property (r5c && rx_valid_in);
endmodule
bind cfsp_ctrl_port cfsp_ctrl_port_checker chk (.core_clk_in, .rst_n_in, .host_wr_in,
   .host_rd_in, .host_addr_in, .host_wdata_in, .host_rdata_out, .tx_valid_out, .tx_ready_in,
   .rx_valid_in, .rx_pop_out, .tx_data_out, .rx_fifo_quadlet_field_in, .mgmt_agent_reset_out,
   .cmd_agent_reset_out, .xfer_engine_reset_out, .xfer_block_size_clear_out,
   .cmd_set_status_send_out, .current_cmd_abort_out, .unsolicited_allowed_flag_in);

// ---- cfsp_tx_sink.sv ----
// Partner: control transmit FIFO sink with stall control
`timescale 1ns/1ps
module cfsp_tx_sink (
   // Stream from the port
   input wire logic core_clk_in,
   input wire logic tx_valid_in,
   input wire logic [32:0] tx_data_in,
   input wire logic stall_in,
   output logic tx_ready_out
);
   // ==========
   // Slow acceptance, so the buffer's hold path is used even unstalled
   logic [32:0] got[$];
   logic slow_reg = 1'b0;
   always @(posedge core_clk_in) begin
      slow_reg <= !slow_reg;
      if (tx_valid_in && tx_ready_out) got.push_back(tx_data_in);
   end
   assign tx_ready_out = slow_reg && !stall_in;
endmodule

// ---- cfsp_ctrl_port_tb.sv ----
// Testbench: scenarios for the control port slice
`timescale 1ns/1ps
module cfsp_ctrl_port_tb
   import cfsp_pkg::*;
;
   logic core_clk_in = 1'b0, rst_n_in = 1'b0, host_wr_in = 1'b0, host_rd_in = 1'b0;
   logic [7:0] host_addr_in = 8'h00, host_wdata_in = 8'h00, host_rdata_out, d;
   logic tx_valid_out, tx_ready_in, rx_valid_in = 1'b0, rx_pop_out, stall = 1'b1, pop_seen;
   logic [32:0] tx_data_out;
   logic [31:0] rx_q = 32'h00000000;
   logic m_o, c_o, x_o, b_o, s_o, a_o, unsol = 1'b0, host_wr_ready_out;
   int fails = 0, samples_checked = 0, cycles = 0;
   cfsp_ctrl_port dut (.core_clk_in, .rst_n_in, .host_addr_in, .host_wr_in, .host_rd_in,
      .host_wdata_in, .host_rdata_out, .host_wr_ready_out, .tx_valid_out, .tx_data_out,
      .tx_ready_in, .rx_valid_in, .rx_fifo_quadlet_field_in(rx_q), .rx_pop_out,
      .mgmt_agent_reset_out(m_o), .cmd_agent_reset_out(c_o), .xfer_engine_reset_out(x_o),
      .xfer_block_size_clear_out(b_o), .cmd_set_status_send_out(s_o),
      .current_cmd_abort_out(a_o), .unsolicited_allowed_flag_in(unsol));
   cfsp_tx_sink sink (.core_clk_in, .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out),
      .stall_in(stall), .tx_ready_out(tx_ready_in));
   // ==========
   // Clock and hang guard; whole run is well under 3000 cycles
   initial forever #12.5 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         test_done;
      end
   end
   task automatic chk(input string n, input logic [32:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // One strobe per byte, with an idle cycle between, so no signal is set twice at an edge
   task automatic wr(input logic [7:0] a, w);
      @(posedge core_clk_in);
      host_addr_in <= a;
      host_wdata_in <= w;
      host_wr_in <= 1'b1;
      @(posedge core_clk_in);
      host_wr_in <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      @(posedge core_clk_in);
      host_addr_in <= a;
      host_rd_in <= 1'b1;
      #1 pop_seen = rx_pop_out;
      @(posedge core_clk_in);
      host_rd_in <= 1'b0;
      #1 r = host_rdata_out;
   endtask
   task automatic wq(input logic [7:0] base, input logic [31:0] q);
      for (int i = 0; i < 4; i++) wr(base + 8'(i), q[31 - 8 * i -: 8]);
   endtask
   task automatic t_reset;
      #1;
      chk("tx_valid", tx_valid_out, 0);
      chk("pulses", {m_o, c_o, x_o, b_o, s_o, a_o}, 0);
      rd(8'h60, d);
      chk("agent_msb", d, 8'h00);
      wr(8'h58, 8'hFF);
      rd(8'h5A, d);
      chk("gap", d, 8'h00);
   endtask
   task automatic t_tx;
      wq(CFSP_FIRST_MORE_BASE, 32'h11223344);
      wq(CFSP_TX_LAST_BASE, 32'h55667788);
      // Second push lands one edge after the lane-3 write is taken
      @(posedge core_clk_in);
      #1;
      chk("wr_ready_full", host_wr_ready_out, 0);
      wq(CFSP_FIRST_MORE_BASE, 32'h99AABBCC);
      @(posedge core_clk_in) stall <= 1'b0;
      repeat (10) @(posedge core_clk_in);
      chk("tx_count", sink.got.size(), 2);
      chk("tx_first", sink.got[0], {1'b0, 32'h11223344});
      chk("tx_last", sink.got[1], {1'b1, 32'h55667788});
   endtask
   task automatic t_rx;
      @(posedge core_clk_in);
      rx_valid_in <= 1'b1;
      rx_q <= 32'hA1B2C3D4;
      for (int i = 0; i < 4; i++) begin
         rd(CFSP_RX_QUAD_BASE + 8'(i), d);
         chk("rx_pop", pop_seen, i == 0);
         chk("rx_byte", d, 8'(32'hA1B2C3D4 >> (24 - 8 * i)));
         // Head changes after the pop; later bytes must come from the stack
         @(posedge core_clk_in);
         rx_valid_in <= 1'b0;
         rx_q <= 32'h5A5A5A5A;
      end
   endtask
   task automatic t_agent;
      logic [15:0] wa[6] = '{16'h6040, 16'h6010, 16'h6004, 16'h6180, 16'h6140, 16'h60A9};
      logic [5:0] ex[6] = '{6'h20, 6'h10, 6'h0C, 6'h02, 6'h01, 6'h00};
      for (int k = 0; k < 6; k++) begin
         wr(wa[k][15:8], wa[k][7:0]);
         chk("agent_pulse", {m_o, c_o, x_o, b_o, s_o, a_o}, ex[k]);
      end
      @(posedge core_clk_in) unsol <= 1'b1;
      rd(8'h61, d);
      chk("unsol_flag", d, 8'h20);
   endtask
   task automatic test_done;
      if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      t_reset;
      t_tx;
      t_rx;
      t_agent;
      test_done;
   end
endmodule
